// ===== rtl/intr_event_pkg.sv
package intr_event_pkg;
    // Register map, byte addresses on the bus
    localparam logic [11:0] NODE_BASE = 12'h000;
    localparam logic [11:0] CH_BASE = 12'h100;
    localparam logic [11:0] STATUS_ADDR = 12'h200;
    localparam logic [11:0] EDGE_ADDR = 12'h204;
    localparam logic [1:0] CH_CTRL_SEL = 2'h0;
    localparam logic [1:0] CH_SRC_SEL = 2'h1;
    localparam logic [1:0] CH_DST_SEL = 2'h2;
    // Node control fields
    localparam int LVL_LSB = 0;
    localparam int LVL_W = 4;
    localparam int EN_BIT = 6;
    localparam int REQ_BIT = 7;
    localparam int MODE_BIT = 8;
    localparam int CH_LSB = 9;
    localparam int CH_W = 3;
    // Channel control fields
    localparam int CNT_LSB = 0;
    localparam int CNT_W = 8;
    localparam int CONT_BIT = 8;
    localparam int INCS_BIT = 9;
    localparam int INCD_BIT = 10;
    localparam int WORD_BIT = 11;
    // Trap numbering
    localparam logic [6:0] TRAP_GROUP0 = 7'h10;
    localparam logic [6:0] TRAP_GROUP1 = 7'h30;
    localparam int GROUP_SIZE = 16;
    localparam int CHANNELS = 8;
    localparam int STACK_DEPTH = 16;
    localparam int RESPONSE_MAX_CYCLES = 8;
    localparam logic [LVL_W-1:0] LVL_RESET = 4'h0;
    localparam logic [CNT_W-1:0] CNT_RESET = 8'h00;

    typedef enum logic [1:0] {
        EDGE_OFF = 2'b00,
        EDGE_RISE = 2'b01,
        EDGE_FALL = 2'b10,
        EDGE_BOTH = 2'b11
    } edge_type;

    typedef enum logic {
        SVC_IDLE = 1'b0,
        SVC_OFFER = 1'b1
    } svc_type;
endpackage

// ===== rtl/intr_event_ctrl.sv
// Behaviour
// - An accepted request reaches the core within about eight clocks.
// - Each node is set to vectored interrupt or event transfer service.
// - A transfer steals exactly one cycle, no suspension, no vector branch.
// - A transfer moves a byte or word, then bumps source, destination or both.
// - Channel counter decrements per transfer, unchanged in continuous mode.
// - Counter reaching zero raises the node's normal vectored interrupt.
// - Eight independent channels, each with own pointers and counter.
// - Each node has a control register: request, enable and priority level.
// - The priority field selects one of sixteen levels.
// - An accepted service is preempted only by strictly higher level.
// - Vector offset equals four times the node's trap number.
// - Fast external inputs detect rising, falling or both edges, set requests.
// - A software trap enters the vector of its trap number.
// - Writing one to a request flag raises an interrupt, peripheral or not.
// - Nodes 0-15 use traps 10-1F hex; the next group starts at 30 hex.
`timescale 1ns/1ps
module intr_event_ctrl #(
    parameter int NODES = 32,
    parameter int EXT_INPUTS = 4,
    parameter int EXT_NODE = 24,
    parameter int AW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Wishbone slave
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic wb_we_i,
    input wire logic [11:0] wb_adr_i,
    input wire logic [3:0] wb_sel_i,
    input wire logic [31:0] wb_dat_i,
    output logic [31:0] wb_dat_o,
    output logic wb_ack_o,
    // Request sources
    input wire logic [NODES-1:0] periph_req,
    input wire logic [EXT_INPUTS-1:0] ext_irq,
    // Core side
    output logic core_irq_req,
    output logic [15:0] core_irq_vector,
    output logic [3:0] core_irq_level,
    input wire logic core_ack,
    input wire logic core_return,
    input wire logic sw_trap_valid,
    input wire logic [6:0] sw_trap_num,
    output logic cpu_steal,
    // Transfer request stream
    output logic xfer_valid,
    input wire logic xfer_ready,
    output logic [AW-1:0] xfer_src,
    output logic [AW-1:0] xfer_dst,
    output logic xfer_word
);
    localparam int NW = $clog2(NODES);
    localparam int BW = 2 * AW + 1;

    if (NODES < 2 || NODES > 2 * intr_event_pkg::GROUP_SIZE || EXT_NODE + EXT_INPUTS > NODES || AW < 2) begin
        $error("intr_event_ctrl: unsupported parameters");
    end

    function automatic logic [6:0] trap_of(input logic [NW-1:0] idx);
        if (int'(idx) < intr_event_pkg::GROUP_SIZE) begin
            trap_of = intr_event_pkg::TRAP_GROUP0 + 7'(idx);
        end else begin
            trap_of = intr_event_pkg::TRAP_GROUP1 + 7'(int'(idx) - intr_event_pkg::GROUP_SIZE);
        end
    endfunction

    function automatic logic [15:0] vector_of(input logic [6:0] trap);
        vector_of = {7'h00, trap, 2'b00};
    endfunction

    // Node state
    logic [3:0] node_lvl [NODES];
    logic [NODES-1:0] node_en;
    logic [NODES-1:0] node_request_flag;
    logic [NODES-1:0] node_mode;
    logic [2:0] node_ch [NODES];
    // Channel state
    logic [7:0] ch_cnt [intr_event_pkg::CHANNELS];
    logic [AW-1:0] ch_src [intr_event_pkg::CHANNELS];
    logic [AW-1:0] ch_dst [intr_event_pkg::CHANNELS];
    logic [intr_event_pkg::CHANNELS-1:0] ch_cont;
    logic [intr_event_pkg::CHANNELS-1:0] ch_incs;
    logic [intr_event_pkg::CHANNELS-1:0] ch_incd;
    logic [intr_event_pkg::CHANNELS-1:0] ch_word;
    // Core service state
    intr_event_pkg::svc_type svc;
    logic [NW-1:0] irq_node;
    logic irq_is_trap;
    logic trap_pend;
    logic [6:0] trap_num;
    logic [3:0] cur_level;
    logic [3:0] lvl_stack [intr_event_pkg::STACK_DEPTH];
    logic [4:0] sp;
    // External edge detection
    logic [EXT_INPUTS-1:0] ext_meta;
    logic [EXT_INPUTS-1:0] ext_sync;
    logic [EXT_INPUTS-1:0] ext_prev;
    logic [2*EXT_INPUTS-1:0] edge_cfg;
    // One-entry skid buffer
    logic buf_skid_valid;
    logic [BW-1:0] buf_skid;

    // Bus decode
    wire bus_req = wb_cyc_i && wb_stb_i && !wb_ack_o;
    wire bus_wr = bus_req && wb_we_i && wb_sel_i[0];
    wire node_hit = wb_adr_i[11:8] == intr_event_pkg::NODE_BASE[11:8] && int'(wb_adr_i[7:2]) < NODES;
    wire ch_hit = wb_adr_i[11:7] == intr_event_pkg::CH_BASE[11:7] && wb_adr_i[3:2] != 2'h3;
    wire [NW-1:0] adr_node = wb_adr_i[NW+1:2];
    wire [2:0] adr_ch = wb_adr_i[6:4];
    wire [1:0] adr_chreg = wb_adr_i[3:2];

    // Arbitration over enabled pending nodes
    logic best_found;
    logic [3:0] best_lvl;
    logic [NW-1:0] best_idx;
    // A trap offer parks no hardware node
    wire hold_node = svc == intr_event_pkg::SVC_OFFER && !irq_is_trap;
    always_comb begin
        best_found = 1'b0;
        best_lvl = 4'h0;
        best_idx = '0;
        for (int i = 0; i < NODES; i++) begin
            if (node_request_flag[i] && node_en[i] && !(hold_node && int'(irq_node) == i)
                && (!best_found || node_lvl[i] > best_lvl)) begin
                best_found = 1'b1;
                best_lvl = node_lvl[i];
                best_idx = NW'(i);
            end
        end
    end

    wire win = best_found && best_lvl > cur_level;
    wire [2:0] win_ch = node_ch[best_idx];
    wire win_xfer_mode = node_mode[best_idx] && (ch_cont[win_ch] || ch_cnt[win_ch] != 8'h00);
    wire buf_in_ready = !buf_skid_valid;
    wire xfer_go = win && win_xfer_mode && buf_in_ready;
    wire [7:0] next_cnt = ch_cnt[win_ch] - 8'h01;
    wire xfer_to_zero = xfer_go && !ch_cont[win_ch] && next_cnt == 8'h00;
    wire offer_vec = svc == intr_event_pkg::SVC_IDLE && (trap_pend || (win && !win_xfer_mode));
    wire accept = svc == intr_event_pkg::SVC_OFFER && core_ack;
    wire [AW-1:0] step = ch_word[win_ch] ? AW'(2) : AW'(1);
    wire [BW-1:0] buf_in = {ch_src[win_ch], ch_dst[win_ch], ch_word[win_ch]};

    // External edges
    logic [EXT_INPUTS-1:0] ext_edge;
    always_comb begin
        for (int k = 0; k < EXT_INPUTS; k++) begin
            ext_edge[k] = (edge_cfg[2*k] && ext_sync[k] && !ext_prev[k])
                || (edge_cfg[2*k+1] && !ext_sync[k] && ext_prev[k]);
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ext_meta <= '0;
            ext_sync <= '0;
            ext_prev <= '0;
        end else begin
            ext_meta <= ext_irq;
            ext_sync <= ext_meta;
            ext_prev <= ext_sync;
        end
    end

    // Node registers: clear, then write, then set so a set wins
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            node_en <= '0;
            node_request_flag <= '0;
            node_mode <= '0;
            for (int i = 0; i < NODES; i++) begin
                node_lvl[i] <= intr_event_pkg::LVL_RESET;
                node_ch[i] <= 3'h0;
            end
        end else begin
            for (int i = 0; i < NODES; i++) begin
                if ((accept && !irq_is_trap && int'(irq_node) == i) || (xfer_go && int'(best_idx) == i)) begin
                    node_request_flag[i] <= 1'b0;
                end
                if (bus_wr && node_hit && int'(adr_node) == i) begin
                    node_lvl[i] <= wb_dat_i[intr_event_pkg::LVL_LSB +: intr_event_pkg::LVL_W];
                    node_en[i] <= wb_dat_i[intr_event_pkg::EN_BIT];
                    node_request_flag[i] <= wb_dat_i[intr_event_pkg::REQ_BIT];
                    node_mode[i] <= wb_sel_i[1] ? wb_dat_i[intr_event_pkg::MODE_BIT] : node_mode[i];
                    node_ch[i] <= wb_sel_i[1] ? wb_dat_i[intr_event_pkg::CH_LSB +: intr_event_pkg::CH_W] : node_ch[i];
                end
                if (periph_req[i] || (xfer_to_zero && int'(best_idx) == i)) begin
                    node_request_flag[i] <= 1'b1;
                end
            end
            for (int k = 0; k < EXT_INPUTS; k++) begin
                if (ext_edge[k]) begin
                    node_request_flag[EXT_NODE + k] <= 1'b1;
                end
            end
        end
    end

    // Channel registers and transfer bookkeeping
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            ch_cont <= '0;
            ch_incs <= '0;
            ch_incd <= '0;
            ch_word <= '0;
            for (int c = 0; c < intr_event_pkg::CHANNELS; c++) begin
                ch_cnt[c] <= intr_event_pkg::CNT_RESET;
                ch_src[c] <= '0;
                ch_dst[c] <= '0;
            end
        end else begin
            if (bus_wr && ch_hit) begin
                case (adr_chreg)
                    intr_event_pkg::CH_CTRL_SEL: begin
                        ch_cnt[adr_ch] <= wb_dat_i[intr_event_pkg::CNT_LSB +: intr_event_pkg::CNT_W];
                        ch_cont[adr_ch] <= wb_dat_i[intr_event_pkg::CONT_BIT];
                        ch_incs[adr_ch] <= wb_dat_i[intr_event_pkg::INCS_BIT];
                        ch_incd[adr_ch] <= wb_dat_i[intr_event_pkg::INCD_BIT];
                        ch_word[adr_ch] <= wb_dat_i[intr_event_pkg::WORD_BIT];
                    end
                    intr_event_pkg::CH_SRC_SEL: begin
                        ch_src[adr_ch] <= wb_dat_i[AW-1:0];
                    end
                    intr_event_pkg::CH_DST_SEL: begin
                        ch_dst[adr_ch] <= wb_dat_i[AW-1:0];
                    end
                    default: begin
                    end
                endcase
            end
            // Hardware update follows the bus write so the pointer step is never lost
            if (xfer_go) begin
                if (!ch_cont[win_ch]) begin
                    ch_cnt[win_ch] <= next_cnt;
                end
                if (ch_incs[win_ch]) begin
                    ch_src[win_ch] <= ch_src[win_ch] + step;
                end
                if (ch_incd[win_ch]) begin
                    ch_dst[win_ch] <= ch_dst[win_ch] + step;
                end
            end
        end
    end

    // Skid buffer: a stalled receiver parks one word, then stops the unit
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            xfer_valid <= 1'b0;
            {xfer_src, xfer_dst, xfer_word} <= '0;
            buf_skid_valid <= 1'b0;
            buf_skid <= '0;
            cpu_steal <= 1'b0;
        end else begin
            cpu_steal <= xfer_go;
            if (!xfer_valid || xfer_ready) begin
                if (buf_skid_valid) begin
                    {xfer_src, xfer_dst, xfer_word} <= buf_skid;
                    xfer_valid <= 1'b1;
                    buf_skid_valid <= 1'b0;
                end else begin
                    {xfer_src, xfer_dst, xfer_word} <= buf_in;
                    xfer_valid <= xfer_go;
                end
            end else if (xfer_go) begin
                buf_skid <= buf_in;
                buf_skid_valid <= 1'b1;
            end
        end
    end

    // Vectored service offer and level nesting
    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            svc <= intr_event_pkg::SVC_IDLE;
            irq_node <= '0;
            irq_is_trap <= 1'b0;
            trap_pend <= 1'b0;
            trap_num <= 7'h00;
            core_irq_req <= 1'b0;
            core_irq_vector <= 16'h0000;
            core_irq_level <= 4'h0;
            cur_level <= intr_event_pkg::LVL_RESET;
            sp <= 5'h00;
            for (int s = 0; s < intr_event_pkg::STACK_DEPTH; s++) begin
                lvl_stack[s] <= 4'h0;
            end
        end else begin
            if (sw_trap_valid && !trap_pend) begin
                trap_pend <= 1'b1;
                trap_num <= sw_trap_num;
            end
            case (svc)
                intr_event_pkg::SVC_IDLE: begin
                    if (offer_vec) begin
                        svc <= intr_event_pkg::SVC_OFFER;
                        core_irq_req <= 1'b1;
                        irq_is_trap <= trap_pend;
                        irq_node <= best_idx;
                        core_irq_vector <= vector_of(trap_pend ? trap_num : trap_of(best_idx));
                        core_irq_level <= trap_pend ? cur_level : best_lvl;
                    end
                end
                intr_event_pkg::SVC_OFFER: begin
                    if (core_ack) begin
                        svc <= intr_event_pkg::SVC_IDLE;
                        core_irq_req <= 1'b0;
                        if (irq_is_trap) begin
                            trap_pend <= 1'b0;
                        end
                        if (int'(sp) < intr_event_pkg::STACK_DEPTH) begin
                            lvl_stack[sp[3:0]] <= cur_level;
                            sp <= sp + 5'h01;
                        end
                        cur_level <= core_irq_level;
                    end
                end
                default: begin
                    svc <= intr_event_pkg::SVC_IDLE;
                end
            endcase
            if (core_return && !accept && sp != 5'h00) begin
                sp <= sp - 5'h01;
                cur_level <= lvl_stack[4'(sp - 5'h01)];
            end
        end
    end

    // Read mux
    logic [31:0] rd_data;
    always_comb begin
        rd_data = 32'h0000_0000;
        if (node_hit) begin
            rd_data[intr_event_pkg::LVL_LSB +: intr_event_pkg::LVL_W] = node_lvl[adr_node];
            rd_data[intr_event_pkg::EN_BIT] = node_en[adr_node];
            rd_data[intr_event_pkg::REQ_BIT] = node_request_flag[adr_node];
            rd_data[intr_event_pkg::MODE_BIT] = node_mode[adr_node];
            rd_data[intr_event_pkg::CH_LSB +: intr_event_pkg::CH_W] = node_ch[adr_node];
        end else if (ch_hit && adr_chreg == intr_event_pkg::CH_CTRL_SEL) begin
            rd_data[intr_event_pkg::CNT_LSB +: intr_event_pkg::CNT_W] = ch_cnt[adr_ch];
            rd_data[intr_event_pkg::CONT_BIT] = ch_cont[adr_ch];
            rd_data[intr_event_pkg::INCS_BIT] = ch_incs[adr_ch];
            rd_data[intr_event_pkg::INCD_BIT] = ch_incd[adr_ch];
            rd_data[intr_event_pkg::WORD_BIT] = ch_word[adr_ch];
        end else if (ch_hit && adr_chreg == intr_event_pkg::CH_SRC_SEL) begin
            rd_data[AW-1:0] = ch_src[adr_ch];
        end else if (ch_hit) begin
            rd_data[AW-1:0] = ch_dst[adr_ch];
        end else if (wb_adr_i == intr_event_pkg::STATUS_ADDR) begin
            rd_data[11:0] = {1'b0, buf_skid_valid, svc, sp, cur_level};
        end else if (wb_adr_i == intr_event_pkg::EDGE_ADDR) begin
            rd_data[2*EXT_INPUTS-1:0] = edge_cfg;
        end
    end

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            wb_ack_o <= 1'b0;
            wb_dat_o <= 32'h0000_0000;
            edge_cfg <= '0;
        end else begin
            wb_ack_o <= bus_req;
            wb_dat_o <= bus_req ? rd_data : 32'h0000_0000;
            if (bus_wr && wb_adr_i == intr_event_pkg::EDGE_ADDR) begin
                edge_cfg <= wb_dat_i[2*EXT_INPUTS-1:0];
            end
        end
    end
endmodule

// ===== bench/intr_event_props.sv
`timescale 1ns/1ps
module intr_event_props #(
    parameter int AW = 16
) (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Register bus
    input wire logic wb_cyc_i,
    input wire logic wb_stb_i,
    input wire logic [31:0] wb_dat_o,
    input wire logic wb_ack_o,
    // Core side
    input wire logic core_irq_req,
    input wire logic [15:0] core_irq_vector,
    input wire logic [3:0] core_irq_level,
    input wire logic core_ack,
    input wire logic cpu_steal,
    // Transfer stream
    input wire logic xfer_valid,
    input wire logic xfer_ready,
    input wire logic [AW-1:0] xfer_src,
    input wire logic [AW-1:0] xfer_dst,
    input wire logic xfer_word
);
    default clocking cb @(posedge clk_sys); endclocking
    default disable iff (!rst_n);

    a_ack_once: assert property (wb_cyc_i && wb_stb_i && !wb_ack_o |=> wb_ack_o)
        else $error("bus ack missing one cycle after request");
    a_ack_pulse: assert property (wb_ack_o |=> !wb_ack_o)
        else $error("bus ack longer than one cycle");
    a_dat_quiet: assert property (!wb_ack_o |-> wb_dat_o == 32'h0)
        else $error("read data not zero outside ack");
    a_offer_held: assert property (core_irq_req && !core_ack |=> core_irq_req
        && $stable(core_irq_vector) && $stable(core_irq_level))
        else $error("offer changed before acceptance");
    a_offer_drop: assert property (core_irq_req && core_ack |=> !core_irq_req)
        else $error("offer not withdrawn after acceptance");
    a_vector_align: assert property (core_irq_req |-> core_irq_vector[1:0] == 2'b00
        && core_irq_vector[15:9] == 7'h00)
        else $error("vector is not four times a trap number");
    a_steal_moves: assert property (cpu_steal |-> xfer_valid)
        else $error("stolen cycle without a transfer");
    a_xfer_hold: assert property (xfer_valid && !xfer_ready |=> xfer_valid
        && $stable(xfer_src) && $stable(xfer_dst) && $stable(xfer_word))
        else $error("transfer changed while stalled");
endmodule

// ===== bench/core_model.sv
`timescale 1ns/1ps
module core_model (
    // Clock and reset
    input wire logic clk_sys,
    input wire logic rst_n,
    // Bench controls
    input wire logic [3:0] ack_wait,
    input wire logic ready_en,
    // Offer from the controller
    input wire logic core_irq_req,
    input wire logic [15:0] core_irq_vector,
    output logic core_ack,
    input wire logic cpu_steal,
    // Transfer stream
    input wire logic xfer_valid,
    output logic xfer_ready,
    input wire logic [15:0] xfer_src,
    input wire logic [15:0] xfer_dst,
    input wire logic xfer_word,
    // Observed results
    output int taken,
    output logic [15:0] vec,
    output int moves,
    output int steals,
    output logic [15:0] last_src,
    output logic [15:0] last_dst,
    output logic last_word
);
    logic [3:0] wait_cnt;

    // Memory side stalls at the bench's will; the buffer must keep words
    assign xfer_ready = ready_en;

    always_ff @(posedge clk_sys or negedge rst_n) begin
        if (!rst_n) begin
            core_ack <= 1'b0;
            wait_cnt <= 4'h0;
            taken <= 0;
            vec <= 16'h0000;
            moves <= 0;
            steals <= 0;
            last_src <= 16'h0000;
            last_dst <= 16'h0000;
            last_word <= 1'b0;
        end else begin
            if (core_ack) begin
                core_ack <= 1'b0;
                wait_cnt <= 4'h0;
            end else if (core_irq_req) begin
                // Slow core: accept only after ack_wait idle cycles
                if (wait_cnt == ack_wait) begin
                    core_ack <= 1'b1;
                    taken <= taken + 1;
                    vec <= core_irq_vector;
                end else begin
                    wait_cnt <= wait_cnt + 4'h1;
                end
            end
            if (xfer_valid && xfer_ready) begin
                moves <= moves + 1;
                last_src <= xfer_src;
                last_dst <= xfer_dst;
                last_word <= xfer_word;
            end
            if (cpu_steal) begin
                steals <= steals + 1;
            end
        end
    end
endmodule

// ===== bench/test_intr_event_ctrl.sv
`timescale 1ns/1ps
module test_intr_event_ctrl;
    logic clk_sys = 1'b0;
    logic rst_n = 1'b0;
    logic wb_cyc_i = 1'b0;
    logic wb_stb_i = 1'b0;
    logic wb_we_i = 1'b0;
    logic [11:0] wb_adr_i = 12'h000;
    logic [3:0] wb_sel_i = 4'hF;
    logic [31:0] wb_dat_i = 32'h0;
    logic [31:0] periph_req = 32'h0;
    logic [3:0] ext_irq = 4'h0;
    logic core_return = 1'b0;
    logic sw_trap_valid = 1'b0;
    logic [6:0] sw_trap_num = 7'h00;
    logic [3:0] ack_wait = 4'h1;
    logic ready_en = 1'b1;
    logic [31:0] wb_dat_o, rd;
    logic wb_ack_o, core_irq_req, core_ack, cpu_steal, xfer_valid, xfer_ready, xfer_word, last_word;
    logic [15:0] core_irq_vector, xfer_src, xfer_dst, vec, last_src, last_dst;
    logic [3:0] core_irq_level;
    int taken, moves, steals, cyc = 0, bad_count = 0, tests_run = 0;

    always #2.5 clk_sys = ~clk_sys;
    intr_event_ctrl DUT (.*);
    core_model partner (.*);

    task automatic wrap_up;
        $display("checks %0d mismatches %0d", tests_run, bad_count);
        if (bad_count == 0 && tests_run > 0) begin
            $display("TEST PASSED");
        end else begin
            $display("TEST FAILED");
        end
        $finish;
    endtask

    always @(posedge clk_sys) begin
        cyc++;
        if (cyc == 20000) begin
            bad_count++;
            wrap_up();
        end
    end

    task automatic chk(input logic [31:0] got, input logic [31:0] exp);
        tests_run++;
        if (got !== exp) begin
            bad_count++;
            $display("CHECK FAILED at %0t: got %h expected %h", $time, got, exp);
        end
    endtask

    task automatic bus(input logic we, input logic [11:0] adr, input logic [31:0] wd);
        int n = 0;
        wb_cyc_i <= 1'b1;
        wb_stb_i <= 1'b1;
        wb_we_i <= we;
        wb_adr_i <= adr;
        wb_dat_i <= wd;
        @(posedge clk_sys);
        while (wb_ack_o !== 1'b1 && n < 16) begin
            @(posedge clk_sys);
            n++;
        end
        chk(wb_ack_o, 32'h1);
        rd = wb_dat_o;
        wb_cyc_i <= 1'b0;
        wb_stb_i <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic wr(input logic [11:0] adr, input logic [31:0] wd);
        bus(1'b1, adr, wd);
    endtask

    task automatic rdchk(input logic [11:0] adr, input logic [31:0] exp);
        bus(1'b0, adr, 32'h0);
        chk(rd, exp);
    endtask

    function automatic logic [11:0] na(input int n);
        return intr_event_pkg::NODE_BASE + 12'(4 * n);
    endfunction

    task automatic pulse(input logic [31:0] m);
        periph_req <= m;
        @(posedge clk_sys);
        periph_req <= 32'h0;
        @(posedge clk_sys);
    endtask

    task automatic ret;
        core_return <= 1'b1;
        @(posedge clk_sys);
        core_return <= 1'b0;
        @(posedge clk_sys);
    endtask

    task automatic expect_vec(input int base, input logic [15:0] v);
        int n = 0;
        while (taken == base && n < 40) begin
            @(posedge clk_sys);
            n++;
        end
        chk(taken - base, 32'h1);
        chk(vec, v);
    endtask

    task automatic t_regs;
        rdchk(na(3), 32'h0);
        wr(na(3), 32'h4F);
        rdchk(na(3), 32'h4F);
        wb_sel_i <= 4'hE;
        wr(na(3), 32'h0);
        wb_sel_i <= 4'hF;
        rdchk(na(3), 32'h4F);
        wr(12'h300, 32'hFFFF_FFFF);
        rdchk(12'h300, 32'h0);
        wr(na(3), 32'h0);
    endtask

    task automatic t_vec;
        int nd[4] = '{0, 15, 16, 31};
        int b, k, tr;
        for (int i = 0; i < 4; i++) begin
            b = taken;
            k = 0;
            tr = (nd[i] < 16) ? 16 + nd[i] : 32 + nd[i];
            wr(na(nd[i]), 32'hC1);
            while (core_irq_req !== 1'b1 && k < 20) begin
                @(posedge clk_sys);
                k++;
            end
            chk(k <= intr_event_pkg::RESPONSE_MAX_CYCLES, 32'h1);
            chk(32'(core_irq_level), 32'h1);
            expect_vec(b, 16'(tr * 4));
            rdchk(na(nd[i]), 32'h41);
            ret();
        end
    endtask

    task automatic t_prio;
        int b;
        wr(na(1), 32'h43);
        wr(na(2), 32'h43);
        wr(na(5), 32'h49);
        b = taken;
        pulse(32'h26);
        expect_vec(b, 16'h0054);
        ret();
        expect_vec(b + 1, 16'h0044);
        repeat (10) @(posedge clk_sys);
        chk(taken - b, 32'h2);
        pulse(32'h20);
        expect_vec(b + 2, 16'h0054);
        ret();
        repeat (10) @(posedge clk_sys);
        chk(taken - b, 32'h3);
        ret();
        expect_vec(b + 3, 16'h0048);
        ret();
    endtask

    task automatic t_ext;
        int b;
        logic exp;
        wr(intr_event_pkg::EDGE_ADDR, 32'h39);
        rdchk(intr_event_pkg::EDGE_ADDR, 32'h39);
        for (int k = 0; k < 4; k++) begin
            wr(na(24 + k), 32'h42);
        end
        for (int k = 0; k < 4; k++) begin
            for (int e = 0; e < 2; e++) begin
                b = taken;
                exp = 1'((8'h39 >> (2 * k + e)) & 8'h01);
                ext_irq[k] <= (e == 0);
                repeat (14) @(posedge clk_sys);
                chk(taken - b, 32'(exp));
                if (exp) begin
                    chk(vec, 32'((8'h38 + k) * 4));
                    ret();
                end
            end
        end
    endtask

    task automatic t_xfer;
        int b = taken;
        int m = moves;
        int s = steals;
        ready_en <= 1'b0;
        wr(12'h130, 32'h0A03);
        wr(12'h134, 32'h1000);
        wr(12'h138, 32'h2000);
        wr(na(4), 32'h742);
        repeat (3) pulse(32'h10);
        // Buffer holds two; the third waits with its flag still set
        rdchk(na(4), 32'h7C2);
        chk(steals - s, 32'h2);
        chk(taken - b, 32'h0);
        rdchk(intr_event_pkg::STATUS_ADDR, 32'h400);
        ready_en <= 1'b1;
        repeat (8) @(posedge clk_sys);
        chk(moves - m, 32'h3);
        chk({last_dst, last_src}, {16'h2000, 16'h1004});
        chk(32'(last_word), 32'h1);
        expect_vec(b, 16'h0050);
        rdchk(12'h130, 32'h0A00);
        ret();
    endtask

    task automatic t_cont;
        int b = taken;
        int m = moves;
        wr(12'h150, 32'h0501);
        wr(12'h154, 32'h4000);
        wr(12'h158, 32'h3000);
        wr(na(6), 32'hB42);
        repeat (2) pulse(32'h40);
        repeat (4) @(posedge clk_sys);
        chk(moves - m, 32'h2);
        chk({last_dst, last_src}, {16'h3001, 16'h4000});
        chk(32'(last_word), 32'h0);
        chk(taken - b, 32'h0);
        rdchk(12'h150, 32'h0501);
        rdchk(12'h134, 32'h1006);
    endtask

    task automatic t_trap;
        int b = taken;
        sw_trap_num <= 7'h2A;
        sw_trap_valid <= 1'b1;
        @(posedge clk_sys);
        sw_trap_valid <= 1'b0;
        expect_vec(b, 16'h00A8);
        ret();
    endtask

    initial begin
        repeat (12) @(posedge clk_sys);
        rst_n <= 1'b1;
        @(posedge clk_sys);
        t_regs();
        $display("registers done");
        t_vec();
        $display("vectors done");
        t_prio();
        $display("priority done");
        t_ext();
        $display("external edges done");
        t_xfer();
        $display("transfers done");
        t_cont();
        $display("continuous done");
        t_trap();
        $display("trap done");
        wrap_up();
    end
endmodule

bind intr_event_ctrl intr_event_props #(.AW(AW)) u_props (.*);
